// ---- ivf_pkg.sv ----
// Constants and types for the vector interrupt and fast interrupt select block.
package ivf_pkg;
    // Structure sizes.
    localparam int NODES     = 16;
    localparam int NODE_W    = 4;
    localparam int NODE_PRIORITY_W    = 4;
    localparam int SP_W      = 4;
    localparam int STACK_D   = 16;
    localparam int FAST_SRCS = 8;
    localparam int LANES     = 4;
    localparam int BYTE_W    = 8;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_IRQ_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FORCED    = 8'h04;
    localparam logic [7:0] OFS_VTB       = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_FAST_PEND = 8'h10;
    localparam logic [7:0] OFS_FAST_CTRL = 8'h14;
    localparam logic [1:0] NODE_REGION   = 2'h1;

    // Field positions.
    localparam int CTRL_GE_BIT   = 0;
    localparam int CTRL_TE_BIT   = 1;
    localparam int NODE_M_BIT    = 7;
    localparam int NODE_P_BIT    = 6;
    localparam int NODE_E_BIT    = 5;
    localparam int FAST_PEND_BIT = 0;
    localparam int FAST_GE_BIT   = 7;
    localparam int FAST_SEL_ON   = 3;

    // Vector table geometry and priority limit.
    localparam logic [31:0]       EXIT_OFS    = 32'h0000_0100;
    localparam int                ENTRY_SHIFT = 2;
    localparam logic [NODE_PRIORITY_W-1:0] NODE_PRIORITY_MAX    = 4'hF;

    // Source node state.
    typedef struct packed {
        logic              p;
        logic              e;
        logic [NODE_PRIORITY_W-1:0] node_priority;
    } ivf_node_t;

    // Core access seen on the vector table locations.
    typedef struct packed {
        logic        valid;
        logic        we;
        logic        word;
        logic [31:0] addr;
    } ivf_vt_acc_t;

    // Whole state of the block.
    typedef struct packed {
        ivf_node_t [NODES-1:0]               node;
        logic                                ge;
        logic                                te;
        logic [NODE_PRIORITY_W-1:0]                   forced;
        logic [31:0]                         vector_table_base;
        logic [NODE_PRIORITY_W-1:0]                   level;
        logic [STACK_D-1:0][NODE_PRIORITY_W-1:0]      stack;
        logic [SP_W-1:0]                     sp;
        logic                                irq_act;
        logic                                fast_pend;
        logic                                fast_ge;
        logic [3:0]                          fast_sel;
        logic                                fast_act;
        logic                                ack;
        logic [31:0]                         rdat;
        logic                                vec_ack;
        logic                                vec_exit;
        logic [31:0]                         vec_entry;
    } ivf_state_t;
endpackage

// ---- ivf_core.sv ----
// Vector interrupt controller with fast interrupt source select and Wishbone registers.
`timescale 1ns/100ps
// Contract
// - Disabled node still pends, never requests.
// - Inactive comparator read gives default vector.
// - Comparator drops when sole node withdraws.
// - Word write at base plus 0x100 exits.
// - Table enable cleared blocks acknowledge and exit.
// - Only word accesses trigger acknowledge or exit.
// - Global enable clear gates next requests only.
// - Maximum forced priority blocks further requests.
// - Encoder uses registered node state, next cycle.
// - Table base always accessible, used immediately; code holds it at zero while standby_irq is low.
// - One of eight fast sources routed.
// - Fast pending latched until cleared; output gateable.
// - Routed fast source detached from its node.
// - Fast registers reset while fast standby cleared.
// - Fast pending bit zero, set/clear by writes.
// - Fast control: enable bit seven, select low.
// - Vector read acknowledges, clears pending, saves level.
// - Fast enable clear waits for inactive request.
// - Select top bit gates routing, low bits pick.
module ivf_core import ivf_pkg::*; (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 wb_cyc,
    input  wire logic                 wb_stb,
    input  wire logic                 wb_we,
    input  wire logic [7:0]           wb_adr,
    input  wire logic [LANES-1:0]     wb_sel,
    input  wire logic [31:0]          wb_dat_w,
    output logic      [31:0]          wb_dat_r,
    output logic                      wb_ack,
    input  wire logic                 standby_irq,
    input  wire logic                 standby_fiq,
    input  wire logic [NODES-1:0]     node_src,
    input  wire ivf_vt_acc_t          vt_acc,
    output logic      [31:0]          vector_entry,
    output logic                      vector_acknowledge,
    output logic                      vector_exit_signal,
    output logic                      normal_irq_req_n,
    output logic                      fast_irq_req_n
);
    ivf_state_t          st_ff;
    ivf_state_t          nxt_st;
    logic [NODE_W-1:0]   win;
    logic [NODE_PRIORITY_W-1:0]   win_node_priority;
    logic                cmp;
    logic                rd_base;
    logic                wr_exit;
    logic                bus_req;
    logic                bus_wr;
    logic                sel_on;
    logic [2:0]          sel_idx;
    logic [NODES-1:0]    src_eff;

    // Matches a word-aligned register offset.
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    // Matches the source node region.
    function automatic logic node_hit(input logic [7:0] adr);
        node_hit = (adr[7:6] == NODE_REGION) && (adr[1:0] == 2'h0);
    endfunction

    // Next state of the whole block.
    always_comb begin
        nxt_st   = st_ff;
        win      = '0;
        win_node_priority = '0;
        // Encoder reads only registered node state, so writes act a cycle later.
        for (int i = 0; i < NODES; i++) begin
            if (st_ff.node[i].p && st_ff.node[i].e && st_ff.node[i].node_priority > win_node_priority) begin
                win      = NODE_W'(i);
                win_node_priority = st_ff.node[i].node_priority;
            end
        end
        cmp     = win_node_priority > st_ff.level;
        sel_on  = st_ff.fast_sel[FAST_SEL_ON];
        sel_idx = st_ff.fast_sel[2:0];
        for (int i = 0; i < NODES; i++) begin
            src_eff[i] = node_src[i] && !(sel_on && i == int'(sel_idx));
        end
        // Hardware actions on the vector table need table enable and a word access.
        rd_base = vt_acc.valid && vt_acc.word && st_ff.te && !vt_acc.we
                  && vt_acc.addr == st_ff.vector_table_base;
        wr_exit = vt_acc.valid && vt_acc.word && st_ff.te && vt_acc.we
                  && vt_acc.addr == st_ff.vector_table_base + EXIT_OFS;
        bus_req = wb_cyc && wb_stb;
        bus_wr  = bus_req && wb_we && st_ff.ack;
        nxt_st.ack      = bus_req && !st_ff.ack;
        nxt_st.vec_ack  = 1'b0;
        nxt_st.vec_exit = wr_exit;

        // Acknowledge or default vector on a base read.
        if (rd_base) begin
            if (cmp) begin
                nxt_st.vec_ack            = 1'b1;
                nxt_st.vec_entry          = st_ff.vector_table_base + ((32'(win) + 32'h1) << ENTRY_SHIFT);
                nxt_st.node[win].p        = 1'b0;
                nxt_st.stack[st_ff.sp]    = st_ff.level;
                nxt_st.sp                 = st_ff.sp + 4'h1;
                nxt_st.level              = win_node_priority;
            end else begin
                nxt_st.vec_entry = st_ff.vector_table_base;
            end
        end
        // Exit restores the interrupted level.
        if (wr_exit && st_ff.sp != '0) begin
            nxt_st.level = st_ff.stack[st_ff.sp - 4'h1];
            nxt_st.sp    = st_ff.sp - 4'h1;
        end
        // A held request stays until read or comparator drop; new ones need gates.
        if (st_ff.irq_act) begin
            nxt_st.irq_act = cmp && !rd_base;
        end else begin
            nxt_st.irq_act = cmp && st_ff.ge && win_node_priority > st_ff.forced;
        end

        // Register writes at the acknowledged edge.
        if (bus_wr && wb_sel[0]) begin
            if (hit(wb_adr, OFS_IRQ_CTRL)) begin
                nxt_st.ge = wb_dat_w[CTRL_GE_BIT];
                nxt_st.te = wb_dat_w[CTRL_TE_BIT];
            end
            if (hit(wb_adr, OFS_FORCED)) begin
                nxt_st.forced = wb_dat_w[NODE_PRIORITY_W-1:0];
            end
            if (node_hit(wb_adr)) begin
                nxt_st.node[wb_adr[5:2]].e    = wb_dat_w[NODE_E_BIT];
                nxt_st.node[wb_adr[5:2]].node_priority = wb_dat_w[NODE_PRIORITY_W-1:0];
                if (wb_dat_w[NODE_M_BIT]) begin
                    nxt_st.node[wb_adr[5:2]].p = wb_dat_w[NODE_P_BIT];
                end
            end
            if (hit(wb_adr, OFS_FAST_PEND)) begin
                nxt_st.fast_pend = wb_dat_w[FAST_PEND_BIT];
            end
            if (hit(wb_adr, OFS_FAST_CTRL)) begin
                nxt_st.fast_ge  = wb_dat_w[FAST_GE_BIT];
                nxt_st.fast_sel = wb_dat_w[3:0];
            end
        end
        if (bus_wr && hit(wb_adr, OFS_VTB)) begin
            for (int b = 0; b < LANES; b++) begin
                if (wb_sel[b]) begin
                    nxt_st.vector_table_base[b*BYTE_W +: BYTE_W] = wb_dat_w[b*BYTE_W +: BYTE_W];
                end
            end
        end

        // Sources set pending after bus and acknowledge clears, so a set beats them; fast standby clear still wins.
        for (int i = 0; i < NODES; i++) begin
            if (src_eff[i]) begin
                nxt_st.node[i].p = 1'b1;
            end
        end
        if (sel_on && node_src[sel_idx]) begin
            nxt_st.fast_pend = 1'b1;
        end
        // Fast output holds while pending; enable gates only a new assertion.
        if (st_ff.fast_act) begin
            nxt_st.fast_act = st_ff.fast_pend;
        end else begin
            nxt_st.fast_act = st_ff.fast_pend && st_ff.fast_ge;
        end

        // Standby flags clear their part; pending flags of nodes keep running.
        if (!standby_irq) begin
            for (int i = 0; i < NODES; i++) begin
                nxt_st.node[i].e    = 1'b0;
                nxt_st.node[i].node_priority = '0;
                nxt_st.node[i].p    = st_ff.node[i].p || src_eff[i];
            end
            nxt_st.ge       = 1'b0;
            nxt_st.te       = 1'b0;
            nxt_st.forced   = '0;
            nxt_st.vector_table_base      = '0;
            nxt_st.level    = '0;
            nxt_st.stack    = '0;
            nxt_st.sp       = '0;
            nxt_st.irq_act  = 1'b0;
            nxt_st.vec_ack  = 1'b0;
            nxt_st.vec_exit = 1'b0;
        end
        if (!standby_fiq) begin
            nxt_st.fast_pend = 1'b0;
            nxt_st.fast_ge   = 1'b0;
            nxt_st.fast_sel  = '0;
            nxt_st.fast_act  = 1'b0;
        end

        // Read data is captured in the request cycle and shown with ack.
        nxt_st.rdat = '0;
        if (bus_req && !st_ff.ack) begin
            if (hit(wb_adr, OFS_IRQ_CTRL)) begin
                nxt_st.rdat[CTRL_GE_BIT] = st_ff.ge;
                nxt_st.rdat[CTRL_TE_BIT] = st_ff.te;
            end
            if (hit(wb_adr, OFS_FORCED)) begin
                nxt_st.rdat[NODE_PRIORITY_W-1:0] = st_ff.forced;
            end
            if (hit(wb_adr, OFS_VTB)) begin
                nxt_st.rdat = st_ff.vector_table_base;
            end
            if (hit(wb_adr, OFS_STATUS)) begin
                nxt_st.rdat[15:0] = {st_ff.fast_act, st_ff.irq_act, cmp, 1'b0,
                                     st_ff.sp, win_node_priority, st_ff.level};
            end
            if (node_hit(wb_adr)) begin
                nxt_st.rdat[NODE_P_BIT]   = st_ff.node[wb_adr[5:2]].p;
                nxt_st.rdat[NODE_E_BIT]   = st_ff.node[wb_adr[5:2]].e;
                nxt_st.rdat[NODE_PRIORITY_W-1:0]   = st_ff.node[wb_adr[5:2]].node_priority;
            end
            if (hit(wb_adr, OFS_FAST_PEND)) begin
                nxt_st.rdat[FAST_PEND_BIT] = st_ff.fast_pend;
            end
            if (hit(wb_adr, OFS_FAST_CTRL)) begin
                nxt_st.rdat[FAST_GE_BIT] = st_ff.fast_ge;
                nxt_st.rdat[3:0]         = st_ff.fast_sel;
            end
        end
    end

    // State register; every field resets to zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register.
    assign wb_dat_r           = st_ff.rdat;
    assign wb_ack             = st_ff.ack;
    assign vector_entry       = st_ff.vec_entry;
    assign vector_acknowledge = st_ff.vec_ack;
    assign vector_exit_signal = st_ff.vec_exit;
    assign normal_irq_req_n   = !st_ff.irq_act;
    assign fast_irq_req_n     = !st_ff.fast_act;

    // Checks of the documented behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_node_pends: assert property (standby_irq && src_eff[0] |=> st_ff.node[0].p)
        else $error("Node source did not set pending.");
    a_default_vec: assert property (rd_base && !cmp && standby_irq
        |=> !vector_acknowledge && vector_entry == $past(st_ff.vector_table_base))
        else $error("Default vector read misbehaved.");
    a_cmp_drop: assert property (st_ff.irq_act && !cmp |=> !st_ff.irq_act)
        else $error("Request held after comparator drop.");
    a_exit_pulse: assert property (wr_exit && standby_irq |=> vector_exit_signal)
        else $error("Exit write gave no exit pulse.");
    a_te_gate: assert property (vector_acknowledge || vector_exit_signal |-> $past(st_ff.te))
        else $error("Table action while table disabled.");
    a_word_only: assert property (vector_acknowledge |-> $past(vt_acc.word))
        else $error("Acknowledge from a narrow access.");
    a_ge_gate: assert property (!st_ff.irq_act && !st_ff.ge |=> !st_ff.irq_act)
        else $error("Request raised with global enable clear.");
    a_ge_hold: assert property (st_ff.irq_act && cmp && !rd_base && standby_irq
        |=> st_ff.irq_act)
        else $error("Active request withdrawn.");
    a_forced_max: assert property (!st_ff.irq_act && st_ff.forced == NODE_PRIORITY_MAX
        |=> !st_ff.irq_act)
        else $error("Request raised at maximum forced priority.");
    a_ack_level: assert property (rd_base && cmp && standby_irq
        |=> vector_acknowledge && st_ff.level == $past(win_node_priority) ##1 !vector_acknowledge)
        else $error("Acknowledge did not raise level.");
    a_fast_latch: assert property (standby_fiq && sel_on && node_src[sel_idx]
        |=> st_ff.fast_pend)
        else $error("Fast source not latched.");
    a_fast_hold: assert property (st_ff.fast_act && st_ff.fast_pend && standby_fiq
        |=> st_ff.fast_act)
        else $error("Fast request cut off.");
    a_fast_stby: assert property (!standby_fiq |=> st_ff.fast_sel == '0 && !st_ff.fast_ge)
        else $error("Fast registers not held in reset.");

    c_ack: cover property (vector_acknowledge);
    c_exit: cover property (vector_acknowledge ##[1:50] vector_exit_signal);
    c_fast: cover property (st_ff.fast_act);
endmodule

// ---- ivf_cpu_model.sv ----
// Processor core model: Wishbone master and vector table access port.
`timescale 1ns/100ps
module ivf_cpu_model import ivf_pkg::*; (
    input  wire logic             ref_clk,
    output logic                  wb_cyc,
    output logic                  wb_stb,
    output logic                  wb_we,
    output logic      [7:0]       wb_adr,
    output logic      [LANES-1:0] wb_sel,
    output logic      [31:0]      wb_dat_w,
    input  wire logic [31:0]      wb_dat_r,
    input  wire logic             wb_ack,
    output ivf_vt_acc_t           vt_acc
);
    // All requests idle at time zero.
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        vt_acc = '0;
    end
    // Classic single cycle held until ack; released lines show inverted junk.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat_w <= d;
        do @(posedge ref_clk); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_adr <= ~a;
        wb_dat_w <= ~d;
    endtask
    // One core access on the vector table port, taken at the returning edge.
    task automatic vt(input logic we, input logic word, input logic [31:0] a);
        @(posedge ref_clk);
        vt_acc <= '{1'b1, we, word, a};
        @(posedge ref_clk);
        vt_acc <= '{1'b0, ~we, ~word, ~a};
    endtask
endmodule

// ---- irq_vector_and_fiq_select_tb_top.sv ----
// Self-checking testbench of the vector and fast interrupt block.
`timescale 1ns/100ps
module irq_vector_and_fiq_select_tb_top import ivf_pkg::*;;
    localparam logic [31:0] VECTOR_TABLE_BASE = 32'h0000_1000;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic standby_irq = 1'b0;
    logic standby_fiq = 1'b0;
    logic [NODES-1:0] node_src = '0;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [LANES-1:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, vector_entry, q;
    ivf_vt_acc_t vt_acc;
    logic vector_acknowledge, vector_exit_signal, normal_irq_req_n, fast_irq_req_n;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    ivf_cpu_model cpu_u (.ref_clk(ref_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .vt_acc(vt_acc));
    ivf_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .standby_irq(standby_irq), .standby_fiq(standby_fiq), .node_src(node_src),
        .vt_acc(vt_acc), .vector_entry(vector_entry),
        .vector_acknowledge(vector_acknowledge), .vector_exit_signal(vector_exit_signal),
        .normal_irq_req_n(normal_irq_req_n), .fast_irq_req_n(fast_irq_req_n));
    // Clock at 125 MHz.
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu_u.bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        cpu_u.bus(1'b0, a, 32'h0, q);
    endtask
    task automatic pulse(input int n);
        @(posedge ref_clk);
        node_src[n] <= 1'b1;
        @(posedge ref_clk);
        node_src[n] <= 1'b0;
    endtask
    // Reset values, table base access and an unmapped read.
    task automatic t_reset();
        rd(OFS_FAST_PEND);
        chk("fast_pend", 32'h0, q);
        rd(OFS_FAST_CTRL);
        chk("fast_ctrl", 32'h0, q);
        wr(OFS_VTB, VECTOR_TABLE_BASE);
        rd(OFS_VTB);
        chk("vtb", VECTOR_TABLE_BASE, q);
        rd(8'h30);
        chk("unmapped", 32'h0, q);
        wr(OFS_IRQ_CTRL, 32'h3);
    endtask
    // Disabled node pends silently, then enabled node is served and exited.
    task automatic t_serve();
        wr(8'h48, 32'h85);
        pulse(2);
        tick(4);
        chk("req_poll", 32'h1, normal_irq_req_n);
        rd(8'h48);
        chk("node_poll", 32'h45, q);
        wr(8'h48, 32'h25);
        tick(1);
        chk("req_next", 32'h1, normal_irq_req_n);
        tick(2);
        chk("req_on", 32'h0, normal_irq_req_n);
        cpu_u.vt(1'b0, 1'b1, VECTOR_TABLE_BASE);
        tick(1);
        chk("ack", 32'h1, vector_acknowledge);
        chk("entry", VECTOR_TABLE_BASE + 32'hC, vector_entry);
        chk("req_off", 32'h1, normal_irq_req_n);
        rd(8'h48);
        chk("node_clr", 32'h25, q);
        cpu_u.vt(1'b1, 1'b1, VECTOR_TABLE_BASE + EXIT_OFS);
        tick(1);
        chk("exit", 32'h1, vector_exit_signal);
    endtask
    // Narrow and disabled accesses, then a withdrawn request meets the default vector.
    task automatic t_default();
        pulse(2);
        cpu_u.vt(1'b0, 1'b0, VECTOR_TABLE_BASE);
        tick(1);
        chk("ack_narrow", 32'h0, vector_acknowledge);
        wr(OFS_IRQ_CTRL, 32'h1);
        cpu_u.vt(1'b0, 1'b1, VECTOR_TABLE_BASE);
        tick(1);
        chk("ack_te", 32'h0, vector_acknowledge);
        cpu_u.vt(1'b1, 1'b1, VECTOR_TABLE_BASE + EXIT_OFS);
        tick(1);
        chk("exit_te", 32'h0, vector_exit_signal);
        wr(OFS_IRQ_CTRL, 32'h3);
        wr(8'h48, 32'hA5);
        tick(3);
        chk("req_drop", 32'h1, normal_irq_req_n);
        cpu_u.vt(1'b0, 1'b1, VECTOR_TABLE_BASE);
        tick(1);
        chk("ack_dflt", 32'h0, vector_acknowledge);
        chk("entry_dflt", VECTOR_TABLE_BASE, vector_entry);
    endtask
    // Global enable and forced priority gate new requests only.
    task automatic t_gate();
        wr(OFS_IRQ_CTRL, 32'h2);
        pulse(2);
        tick(4);
        chk("req_ge0", 32'h1, normal_irq_req_n);
        wr(OFS_IRQ_CTRL, 32'h3);
        tick(3);
        chk("req_ge1", 32'h0, normal_irq_req_n);
        wr(OFS_IRQ_CTRL, 32'h2);
        tick(2);
        chk("req_held", 32'h0, normal_irq_req_n);
        cpu_u.vt(1'b0, 1'b1, VECTOR_TABLE_BASE);
        cpu_u.vt(1'b1, 1'b1, VECTOR_TABLE_BASE + EXIT_OFS);
        wr(OFS_IRQ_CTRL, 32'h3);
        wr(OFS_FORCED, 32'hF);
        pulse(2);
        tick(4);
        chk("req_forced", 32'h1, normal_irq_req_n);
        wr(8'h48, 32'h80);
        rd(8'h48);
        chk("node_cleared", 32'h0, q);
    endtask
    // Every fast select code, latching, detaching and late disable.
    task automatic t_fast();
        for (int k = 0; k < FAST_SRCS; k++) begin
            wr(OFS_FAST_CTRL, 32'h88 | k);
            pulse(k);
            tick(2);
            chk("fast_req", 32'h0, fast_irq_req_n);
            rd(OFS_FAST_PEND);
            chk("fast_pend", 32'h1, q);
            rd(8'(8'h40 + 4 * k));
            chk("node_detach", 32'h0, q & 32'h40);
            wr(OFS_FAST_CTRL, k);
            chk("fast_hold", 32'h0, fast_irq_req_n);
            wr(OFS_FAST_PEND, 32'h0);
            tick(2);
            chk("fast_off", 32'h1, fast_irq_req_n);
        end
        wr(OFS_FAST_CTRL, 32'h03);
        pulse(3);
        rd(OFS_FAST_PEND);
        chk("sel_none", 32'h0, q);
        wr(OFS_FAST_PEND, 32'h1);
        rd(OFS_FAST_PEND);
        chk("pend_sw", 32'h1, q);
        standby_fiq <= 1'b0;
        tick(1);
        wr(OFS_FAST_CTRL, 32'h8B);
        rd(OFS_FAST_CTRL);
        chk("fast_stby", 32'h0, q);
        standby_fiq <= 1'b1;
        standby_irq <= 1'b0;
        tick(2);
        rd(OFS_VTB);
        chk("vtb_stby", 32'h0, q);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Reset, leave standby, then run the scenarios.
    initial begin
        tick(16);
        rst_n <= 1'b1;
        standby_irq <= 1'b1;
        standby_fiq <= 1'b1;
        tick(2);
        t_reset();
        t_serve();
        t_default();
        t_gate();
        t_fast();
        report_and_stop();
    end
endmodule
